/* hdl/pml_pkg.sv */
// constants and types of the power monitor fault-limit block
`default_nettype none
package pml_pkg;
	localparam int CLK_MHZ = 20;
	localparam int MATH_US = 25;
	localparam int RES_W   = 16;
	localparam int POW_W   = 24;
	localparam int LIM_W   = 16;
	localparam int CNT_W   = 24;
	localparam int FLT_N   = 3;
	localparam int ST_W    = 4;

	localparam logic [7:0] OFF_CFG    = 8'h00;
	localparam logic [7:0] OFF_ADC    = 8'h04;
	localparam logic [7:0] OFF_CUR    = 8'h08;
	localparam logic [7:0] OFF_BUS    = 8'h0C;
	localparam logic [7:0] OFF_TEMP   = 8'h10;
	localparam logic [7:0] OFF_POW    = 8'h14;
	localparam logic [7:0] OFF_COL    = 8'h18;
	localparam logic [7:0] OFF_BUSOV  = 8'h1C;
	localparam logic [7:0] OFF_PWRLIM = 8'h20;
	localparam logic [7:0] OFF_STAT   = 8'h24;
	localparam logic [7:0] OFF_MASK   = 8'h28;
	localparam logic [7:0] OFF_FLT    = 8'h2C;

	localparam logic [15:0] ADC_RST    = 16'hFB68;
	localparam logic [15:0] COL_RST    = 16'h7FFF;
	localparam logic [15:0] BUSOV_RST  = 16'h7FFF;
	localparam logic [15:0] PWRLIM_RST = 16'hFFFF;
	localparam logic [3:0]  MASK_RST   = 4'h0;

	localparam int CFG_SRST_BIT  = 15;
	localparam int ADC_CONT_BIT  = 15;
	localparam int ADC_BUS_LSB   = 9;
	localparam int ADC_SHUNT_LSB = 6;
	localparam int ADC_TEMP_LSB  = 3;
	localparam int FLT_CUR       = 0;
	localparam int FLT_BUS       = 1;
	localparam int FLT_POW       = 2;
	localparam int ST_CNVR       = 3;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_TEMP  = 2'b01,
		PH_SHUNT = 2'b11,
		PH_BUS   = 2'b10
	} pml_phase_type;

	// conversion time in microseconds for a 3-bit code
	function automatic int conv_us(input logic [2:0] code);
		case (code)
			3'h0: conv_us = 50;
			3'h1: conv_us = 84;
			3'h2: conv_us = 150;
			3'h3: conv_us = 280;
			3'h4: conv_us = 540;
			3'h5: conv_us = 1052;
			3'h6: conv_us = 2074;
			default: conv_us = 4120;
		endcase
	endfunction
endpackage
`default_nettype wire

/* hdl/pml_conv_seq.sv */
// conversion sequencer: temperature, shunt, bus phases
`timescale 1ns/10ps
`default_nettype none
module pml_conv_seq
	import pml_pkg::*;
#(
	parameter int CYC_PER_US = CLK_MHZ
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// control
	input  wire logic       runCont,
	input  wire logic [2:0] tempCode,
	input  wire logic [2:0] shuntCode,
	input  wire logic [2:0] busCode,
	// phase ends and busy
	output logic            tempDone,
	output logic            shuntDone,
	output logic            busDone,
	output logic            busy
);
	pml_phase_type    phase;
	pml_phase_type    next_phase;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] limit;
	logic             last;

	always_comb begin
		case (phase)
			PH_TEMP:  limit = CNT_W'(conv_us(tempCode) * CYC_PER_US - 1);
			PH_SHUNT: limit = CNT_W'(conv_us(shuntCode) * CYC_PER_US - 1);
			PH_BUS:   limit = CNT_W'(conv_us(busCode) * CYC_PER_US - 1);
			default:  limit = '0;
		endcase
	end
	// >= so a code change mid-phase cannot strand the counter
	assign last = (phase != PH_IDLE) && (cnt >= limit);

	always_comb begin
		case (phase)
			PH_IDLE:  next_phase = runCont ? PH_TEMP : PH_IDLE;
			PH_TEMP:  next_phase = last ? PH_SHUNT : PH_TEMP;
			PH_SHUNT: next_phase = last ? PH_BUS : PH_SHUNT;
			PH_BUS:   next_phase = !last ? PH_BUS : (runCont ? PH_TEMP : PH_IDLE);
			default:  next_phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= PH_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
		end else if (last || phase == PH_IDLE) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	assign tempDone  = last && phase == PH_TEMP;
	assign shuntDone = last && phase == PH_SHUNT;
	assign busDone   = last && phase == PH_BUS;
	assign busy      = phase != PH_IDLE;

	property p_temp_then_shunt;
		@(posedge sys_clk) disable iff (!rst_b)
		tempDone |=> phase == PH_SHUNT && cnt == '0;
	endproperty
	a_temp_then_shunt: assert property (p_temp_then_shunt)
		else $error("shunt phase did not follow temperature");
endmodule
`default_nettype wire

/* hdl/pml_limit_cmp.sv */
// limit comparators for current, bus voltage and power
`timescale 1ns/10ps
`default_nettype none
module pml_limit_cmp
	import pml_pkg::*;
(
	// results
	input  wire logic [RES_W-1:0] curRes,
	input  wire logic [RES_W-1:0] busRes,
	input  wire logic [POW_W-1:0] powRes,
	// limits
	input  wire logic [LIM_W-1:0] curLim,
	input  wire logic [LIM_W-1:0] busLim,
	input  wire logic [LIM_W-1:0] powLim,
	// over-limit flags
	output logic [FLT_N-1:0]      overLimit
);
	// signed, same units as the result
	assign overLimit[FLT_CUR] = $signed(curRes) > $signed(curLim);
	assign overLimit[FLT_BUS] = $signed(busRes) > $signed(busLim);
	// one limit count is 256 power counts
	assign overLimit[FLT_POW] = powRes[POW_W-1 -: LIM_W] > powLim;
endmodule
`default_nettype wire

/* hdl/pml_top.sv */
// power monitor fault-limit block with apb registers
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pml_top
	import pml_pkg::*;
#(
	parameter int CYC_PER_US = CLK_MHZ
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	// converted samples from the front end
	input  wire logic [RES_W-1:0] tempSample,
	input  wire logic [RES_W-1:0] currentSample,
	input  wire logic [RES_W-1:0] busSample,
	input  wire logic [POW_W-1:0] powerSample,
	// alert and interrupt
	output logic                  alertOut,
	output logic                  irq
);
	localparam int MATH_CYC = MATH_US * CYC_PER_US;
	localparam int MAX_CYC  = 4120 * CYC_PER_US;

	if (CYC_PER_US < 1 || MAX_CYC >= (1 << CNT_W)) begin : g_bad_rate
		$error("CYC_PER_US out of range");
	end

	// configuration and status
	logic [15:0]      adcCfg;
	logic [LIM_W-1:0] colLimit;
	logic [LIM_W-1:0] busOvervoltageLimit;
	logic [LIM_W-1:0] powLimit;
	logic [ST_W-1:0]  mask;
	logic [ST_W-1:0]  status;
	logic [ST_W-1:0]  next_status;

	// results
	logic [RES_W-1:0] tempRes;
	logic [RES_W-1:0] curRes;
	logic [RES_W-1:0] busRes;
	logic [POW_W-1:0] powRes;
	logic [RES_W-1:0] tempStage;
	logic [RES_W-1:0] curStage;
	logic [RES_W-1:0] busStage;
	logic [POW_W-1:0] powStage;
	logic [FLT_N-1:0] fault;
	logic [FLT_N-1:0] cmpOut;

	// sequencing
	logic             tempDone;
	logic             shuntDone;
	logic             busDone;
	logic             seqBusy;
	logic             mathBusy;
	logic [CNT_W-1:0] mathCnt;
	logic             resultsLoad;

	// bus
	logic             wrEn;
	logic             rdSetup;
	logic             srstReq;
	logic [31:0]      rdMux;

	function automatic logic is_mapped(input logic [7:0] addr);
		case (addr)
			OFF_CFG, OFF_ADC, OFF_CUR, OFF_BUS, OFF_TEMP, OFF_POW,
			OFF_COL, OFF_BUSOV, OFF_PWRLIM, OFF_STAT, OFF_MASK,
			OFF_FLT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	pml_conv_seq #(
		.CYC_PER_US (CYC_PER_US)
	) u_seq (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.runCont   (adcCfg[ADC_CONT_BIT]),
		.tempCode  (adcCfg[ADC_TEMP_LSB +: 3]),
		.shuntCode (adcCfg[ADC_SHUNT_LSB +: 3]),
		.busCode   (adcCfg[ADC_BUS_LSB +: 3]),
		.tempDone  (tempDone),
		.shuntDone (shuntDone),
		.busDone   (busDone),
		.busy      (seqBusy)
	);

	// compare staged values so results and flags move together
	pml_limit_cmp u_cmp (
		.curRes    (curStage),
		.busRes    (busStage),
		.powRes    (powStage),
		.curLim    (colLimit),
		.busLim    (busOvervoltageLimit),
		.powLim    (powLimit),
		.overLimit (cmpOut)
	);

	// apb: zero wait states, error on unmapped address
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign wrEn    = psel && penable && pwrite && is_mapped(paddr);
	assign rdSetup = psel && !penable && !pwrite;
	assign srstReq = wrEn && paddr == OFF_CFG && pwdata[CFG_SRST_BIT];

	// configuration and limits; power-on and soft reset defaults
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			adcCfg              <= ADC_RST;
			colLimit            <= COL_RST;
			busOvervoltageLimit <= BUSOV_RST;
			powLimit            <= PWRLIM_RST;
			mask                <= MASK_RST;
		end else if (srstReq) begin
			adcCfg              <= ADC_RST;
			colLimit            <= COL_RST;
			busOvervoltageLimit <= BUSOV_RST;
			powLimit            <= PWRLIM_RST;
			mask                <= MASK_RST;
		end else if (wrEn) begin
			case (paddr)
				OFF_ADC:    adcCfg <= pwdata[15:0];
				OFF_COL:    colLimit <= pwdata[LIM_W-1:0];
				OFF_BUSOV:  busOvervoltageLimit <= pwdata[LIM_W-1:0];
				OFF_PWRLIM: powLimit <= pwdata[LIM_W-1:0];
				OFF_MASK:   mask <= pwdata[ST_W-1:0];
				default:    ;
			endcase
		end
	end

	// capture each sample as its phase ends
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tempStage <= '0;
			curStage  <= '0;
			busStage  <= '0;
			powStage  <= '0;
		end else begin
			if (tempDone) begin
				tempStage <= tempSample;
			end
			if (shuntDone) begin
				curStage <= currentSample;
			end
			if (busDone) begin
				busStage <= busSample;
				powStage <= powerSample;
			end
		end
	end

	// background arithmetic delay after the bus phase
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mathBusy <= 1'b0;
			mathCnt  <= '0;
		end else if (busDone) begin
			mathBusy <= 1'b1;
			mathCnt  <= CNT_W'(MATH_CYC - 1);
		end else if (mathBusy && mathCnt == '0) begin
			mathBusy <= 1'b0;
		end else if (mathBusy) begin
			mathCnt <= mathCnt - 1'b1;
		end
	end
	assign resultsLoad = mathBusy && mathCnt == '0;

	// faults only change when a finished result is compared
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tempRes  <= '0;
			curRes   <= '0;
			busRes   <= '0;
			powRes   <= '0;
			fault    <= '0;
			alertOut <= 1'b0;
		end else if (resultsLoad) begin
			tempRes  <= tempStage;
			curRes   <= curStage;
			busRes   <= busStage;
			powRes   <= powStage;
			fault    <= cmpOut;
			alertOut <= |cmpOut;
		end
	end

	// sticky status, write one to clear; a new event wins
	always_comb begin
		next_status = status;
		if (wrEn && paddr == OFF_STAT) begin
			next_status = status & ~pwdata[ST_W-1:0];
		end
		if (resultsLoad) begin
			next_status = next_status | {1'b1, cmpOut};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & mask);
		end
	end

	// read data is latched in the setup phase
	always_comb begin
		case (paddr)
			OFF_ADC:    rdMux = {16'h0000, adcCfg};
			OFF_CUR:    rdMux = sext16(curRes);
			OFF_BUS:    rdMux = sext16(busRes);
			OFF_TEMP:   rdMux = sext16(tempRes);
			OFF_POW:    rdMux = {8'h00, powRes};
			OFF_COL:    rdMux = {16'h0000, colLimit};
			OFF_BUSOV:  rdMux = {16'h0000, busOvervoltageLimit};
			OFF_PWRLIM: rdMux = {16'h0000, powLimit};
			OFF_STAT:   rdMux = {28'h0000000, status};
			OFF_MASK:   rdMux = {28'h0000000, mask};
			OFF_FLT:    rdMux = {29'h0000000, fault};
			default:    rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
		end else if (rdSetup) begin
			prdata <= is_mapped(paddr) ? rdMux : 32'h00000000;
		end
	end

	// helper state for the checks below
	logic             firstCycle;
	logic             latRun;
	logic [CNT_W-1:0] latCnt;
	logic [CNT_W-1:0] latBound;
	logic [CNT_W-1:0] busBound;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			firstCycle <= 1'b1;
		end else begin
			firstCycle <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			latRun <= 1'b0;
			latCnt <= '0;
		end else if (shuntDone) begin
			latRun <= 1'b1;
			latCnt <= '0;
		end else if (resultsLoad) begin
			latRun <= 1'b0;
		end else if (latRun) begin
			latCnt <= latCnt + 1'b1;
		end
	end
	assign busBound = CNT_W'((conv_us(adcCfg[ADC_BUS_LSB +: 3]) + MATH_US) * CYC_PER_US);
	// keep the largest bound seen: a lowered code cannot cut a phase already past it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			latBound <= '0;
		end else if (shuntDone || (latRun && busBound > latBound)) begin
			latBound <= busBound;
		end
	end

	property p_cont_default;
		@(posedge sys_clk) disable iff (!rst_b)
		firstCycle |-> ##[1:2] seqBusy;
	endproperty
	a_cont_default: assert property (p_cont_default)
		else $error("conversions did not start after reset");

	property p_reset_values;
		@(posedge sys_clk) disable iff (!rst_b)
		firstCycle |-> adcCfg == ADC_RST && colLimit == COL_RST
			&& busOvervoltageLimit == BUSOV_RST && powLimit == PWRLIM_RST;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("settings not at defaults after reset");

	property p_cur_cmp;
		@(posedge sys_clk) disable iff (!rst_b)
		resultsLoad && !wrEn |=> fault[FLT_CUR] == ($signed(curRes) > $signed(colLimit));
	endproperty
	a_cur_cmp: assert property (p_cur_cmp)
		else $error("current fault disagrees with limit");

	property p_bus_cmp;
		@(posedge sys_clk) disable iff (!rst_b)
		resultsLoad && !wrEn |=> fault[FLT_BUS] == ($signed(busRes) > $signed(busOvervoltageLimit));
	endproperty
	a_bus_cmp: assert property (p_bus_cmp)
		else $error("bus fault disagrees with limit");

	property p_pow_cmp;
		@(posedge sys_clk) disable iff (!rst_b)
		resultsLoad && !wrEn |=> fault[FLT_POW] == (powRes[23:8] > powLimit);
	endproperty
	a_pow_cmp: assert property (p_pow_cmp)
		else $error("power fault disagrees with limit");

	property p_signed_read;
		@(posedge sys_clk) disable iff (!rst_b)
		rdSetup && paddr == OFF_CUR |=> prdata == {{16{$past(curRes[15])}}, $past(curRes)};
	endproperty
	a_signed_read: assert property (p_signed_read)
		else $error("current read not sign extended");

	property p_latency;
		@(posedge sys_clk) disable iff (!rst_b)
		resultsLoad && latRun |-> latCnt <= latBound;
	endproperty
	a_latency: assert property (p_latency)
		else $error("result later than latency bound");

	property p_fault_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		!resultsLoad |=> $stable(fault) && $stable(alertOut);
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault changed without a compare");

	property p_alert_follow;
		@(posedge sys_clk) disable iff (!rst_b)
		resultsLoad |=> alertOut == $past(|cmpOut) ##1 alertOut == (|fault);
	endproperty
	a_alert_follow: assert property (p_alert_follow)
		else $error("alert does not follow latest compare");

	property p_seq_bus_after_shunt;
		@(posedge sys_clk) disable iff (!rst_b)
		shuntDone |-> !busDone ##1 (seqBusy && !tempDone)[*2];
	endproperty
	a_seq_bus_after_shunt: assert property (p_seq_bus_after_shunt)
		else $error("bus phase did not follow shunt");
endmodule
`default_nettype wire

/* test/pml_host_model.sv */
// host model: apb master that programs and reads the block
`timescale 1ns/10ps
`default_nettype none
module pml_host_model
	import pml_pkg::*;
(
	// clock
	input  wire logic        sys_clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h00000000;
	end

	// request held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep looking valid
		paddr <= ~a;
		pwdata <= ~d;
		if (n >= 64) begin
			tb_top.err_total++;
			tb_top.report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h00000000, q, e);
	endtask

	// settings are lost on every power cycle, so the host writes them again
	task automatic setup(input logic [31:0] adc, input logic [15:0] col);
		wr(OFF_ADC, adc);
		wr(OFF_COL, {16'h0000, col});
	endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the power monitor fault-limit block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pml_pkg::*;
	localparam int CONV0 = 50;
	localparam int CONVD = 1052;
	// worst delay, plus load edge and sampling lag
	localparam int LAT   = 2 * CONV0 + CONV0 + CONV0 + MATH_US + 2;
	logic             sys_clk = 1'b0;
	logic             rst_b = 1'b0;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             alertOut;
	logic             irq;
	logic [RES_W-1:0] tempSample = 16'h02A8;
	logic [RES_W-1:0] currentSample = 16'hF000;
	logic [RES_W-1:0] busSample = 16'h0F00;
	logic [POW_W-1:0] powerSample = 24'h0DBBA0;
	logic [31:0]      rd;
	logic             er;
	int               cyc = 0;
	int               err_total = 0;
	int               total_checks = 0;

	pml_top #(.CYC_PER_US(1)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tempSample(tempSample), .currentSample(currentSample),
		.busSample(busSample), .powerSample(powerSample), .alertOut(alertOut), .irq(irq));
	pml_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic chk_bit(input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		host.rd(a, rd, er);
		chk(exp, rd);
	endtask

	task automatic set_in(input logic [15:0] c, input logic [15:0] b, input logic [23:0] p);
		@(posedge sys_clk);
		currentSample <= c;
		busSample <= b;
		powerSample <= p;
	endtask

	task automatic wait_pin(input logic useIrq, input logic v);
		int n;
		n = 0;
		while ((useIrq ? irq : alertOut) !== v && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 4000) begin
			err_total++;
			report_and_stop();
		end
	endtask

	// clears all status, then polls until a fresh result load
	task automatic wait_load;
		int n;
		host.wr(OFF_STAT, 32'h0000000F);
		n = 0;
		do begin
			host.rd(OFF_STAT, rd, er);
			n++;
		end while (rd[ST_CNVR] !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			err_total++;
			report_and_stop();
		end
	endtask

	// a result may come from a sample taken before the change
	task automatic loads2;
		wait_load();
		wait_load();
	endtask

	task automatic t_defaults;
		rchk(OFF_ADC, 32'h0000FB68);
		rchk(OFF_CFG, 32'h00000000);
		rchk(OFF_COL, 32'h00007FFF);
		rchk(OFF_BUSOV, 32'h00007FFF);
		rchk(OFF_PWRLIM, 32'h0000FFFF);
		rchk(OFF_MASK, 32'h00000000);
		rchk(8'h30, 32'h00000000);
		chk_bit(1'b1, er);
	endtask

	task automatic t_power_up(input int t0);
		int el;
		wait_load();
		el = cyc - t0;
		chk_bit(1'b1, el >= 3 * CONVD + MATH_US && el < 3 * CONVD + MATH_US + 16);
		rchk(OFF_CUR, 32'hFFFFF000);
		rchk(OFF_TEMP, 32'h000002A8);
		rchk(OFF_BUS, 32'h00000F00);
		rchk(OFF_POW, 32'h000DBBA0);
		chk_bit(1'b0, alertOut);
	endtask

	// time between two result loads, seen on the ready interrupt
	task automatic period_chk(input int exp);
		int t1;
		host.wr(OFF_MASK, 32'h00000008);
		host.wr(OFF_STAT, 32'h0000000F);
		wait_pin(1'b1, 1'b0);
		wait_pin(1'b1, 1'b1);
		t1 = cyc;
		host.wr(OFF_STAT, 32'h00000008);
		wait_pin(1'b1, 1'b0);
		wait_pin(1'b1, 1'b1);
		chk(exp, cyc - t1);
		host.wr(OFF_MASK, 32'h00000000);
	endtask

	task automatic t_fast;
		host.setup(32'h00008000, 16'h445C);
		host.wr(OFF_MASK, 32'h00000000);
		loads2();
		chk_bit(1'b0, irq);
		period_chk(3 * CONV0);
	endtask

	task automatic t_limits;
		logic [15:0] c [5] = '{16'h445C, 16'h445C, 16'h445C, 16'h445D, 16'h8000};
		logic [15:0] b [5] = '{16'h1400, 16'h1401, 16'h1400, 16'h1401, 16'h1400};
		logic [23:0] p [5] = '{24'h0DBBFF, 24'h0DBBFF, 24'h0DBC00, 24'h0DBC00, 24'h0DBBA0};
		logic [2:0]  f [5] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h0};
		host.wr(OFF_BUSOV, 32'h00001400);
		host.wr(OFF_PWRLIM, 32'h00000DBB);
		for (int i = 0; i < 5; i++) begin
			set_in(c[i], b[i], p[i]);
			loads2();
			rchk(OFF_FLT, {29'h0, f[i]});
			chk_bit(|f[i], alertOut);
		end
		rchk(OFF_CUR, 32'hFFFF8000);
	endtask

	task automatic t_latency_irq;
		int t1;
		repeat (37) @(posedge sys_clk);
		set_in(16'h445D, 16'h1400, 24'h0DBBA0);
		t1 = cyc;
		wait_pin(1'b0, 1'b1);
		chk_bit(1'b1, cyc - t1 <= LAT);
		host.wr(OFF_MASK, 32'h00000001);
		repeat (2) @(posedge sys_clk);
		chk_bit(1'b1, irq);
		set_in(16'h0100, 16'h1400, 24'h0DBBA0);
		loads2();
		chk_bit(1'b0, alertOut);
		chk_bit(1'b0, irq);
		host.wr(OFF_MASK, 32'h00000000);
	endtask

	// a short spike between sample points must go unseen
	task automatic t_phase;
		wait_load();
		set_in(16'h7FFF, 16'h1400, 24'h0DBBA0);
		repeat (4) @(posedge sys_clk);
		set_in(16'h0100, 16'h1400, 24'h0DBBA0);
		host.wr(OFF_STAT, 32'h00000001);
		loads2();
		rchk(OFF_STAT, 32'h00000008);
		chk_bit(1'b0, alertOut);
	endtask

	task automatic t_soft;
		host.wr(OFF_COL, 32'h00001234);
		host.wr(OFF_CUR, 32'h00005555);
		rchk(OFF_CUR, 32'h00000100);
		host.wr(OFF_CFG, 32'h00008000);
		rchk(OFF_COL, 32'h00007FFF);
		rchk(OFF_ADC, 32'h0000FB68);
		host.setup(32'h00008000, 16'h445C);
		rchk(OFF_COL, 32'h0000445C);
	endtask

	// distinct codes per phase: temp 50, shunt 84, bus 150
	task automatic t_codes;
		host.setup(32'h00008440, 16'h445C);
		period_chk(CONV0 + 84 + 150);
	endtask

	// without continuous run the sequencer stops after its bus phase
	task automatic t_stop;
		host.wr(OFF_ADC, 32'h00000000);
		repeat (300) @(posedge sys_clk);
		host.wr(OFF_STAT, 32'h0000000F);
		repeat (400) @(posedge sys_clk);
		rchk(OFF_STAT, 32'h00000000);
		host.wr(OFF_ADC, 32'h00008000);
		wait_load();
		rchk(OFF_STAT, 32'h00000008);
	endtask

	initial begin
		int t0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		t0 = cyc;
		t_defaults();
		t_power_up(t0);
		t_fast();
		t_limits();
		t_latency_irq();
		t_phase();
		t_soft();
		t_codes();
		t_stop();
		report_and_stop();
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
